// ### cwdt_pkg.sv
/*
  constants shared by the watchdog block: register offsets, control
  field positions, command codes, reset values and timing counts.
  assumes fc is the system clock itself, one fc period per CLK_SYS cycle.
*/
package cwdt_pkg;

  // register offsets on the byte-wide register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CMD = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;

  // control register fields
  localparam int CTL_EN_BIT = 3;
  localparam int CTL_PER_HI = 2;
  localparam int CTL_PER_LO = 1;
  localparam int CTL_ACT_BIT = 0;

  // command codes
  localparam logic [7:0] CMD_CLEAR = 8'h4e;
  localparam logic [7:0] CMD_DISABLE = 8'hb1;
  localparam logic [7:0] CMD_TRAP = 8'hd2;

  // values after reset
  localparam logic RST_EN_BIT = 1'b1;
  localparam logic RST_ACT = 1'b1;
  localparam logic [1:0] RST_PER = 2'h0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // divider tap exponents for period code 00; each code step is two taps
  localparam int FC_TAP_EXP0 = 23;
  localparam int FS_TAP_EXP0 = 15;
  localparam int BIN_W = 2;

  // internal reset request length, in fc periods, and its cycle count
  localparam int RST_TIME_FC = 24;
  localparam int FC_CYC_PER_PERIOD = 1;
  localparam int RST_HOLD_CYC = RST_TIME_FC * FC_CYC_PER_PERIOD;

  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_NMI = 2'b01,
    OUT_RST = 2'b10
  } cwdt_out_t;

endpackage

// ### cwdt_bincnt.sv
/*
  two-stage binary counter that follows the divider tap.
  assumes tick is a one-cycle pulse on the same clock; clear wins
  over hold and tick.
*/
`timescale 1ns/1ps
module cwdt_bincnt #(
  parameter int W = cwdt_pkg::BIN_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic clr,
  input wire logic hold,
  input wire logic tick,
  output logic [W-1:0] cnt,
  output logic ovf
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic step;

  assign step = tick && !hold && !clr;
  // wrap from all ones marks the overflow
  assign ovf = step && (&cnt_q);
  assign cnt_d = clr ? '0 : (step ? cnt_q + W'(1) : cnt_q);
  assign cnt = cnt_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ### cwdt_top.sv
/*
  watchdog timer: free-running dividers on fc and fs, a tap select,
  a two-stage binary counter, control and command registers and the
  overflow output sequencer (interrupt or internal reset request).
  assumes fc equals CLK_SYS, fs arrives asynchronously on a pin and
  the mode levels come from logic on CLK_SYS.
*/
//
// Contract
// - action powers up reset; interrupt choice sticks
// - enable bit is one after reset
// - overflow with reset action requests reset
// - overflow with interrupt action raises interrupt
// - count frozen in stop, idle, sleep
// - clear resets counter, divider keeps running
// - period code picks fc or fs tap; the code picks only the tap depth, SLOW_MODE and DIV_TAP_SEL pick fc or fs
// - command codes clear, disable, trap; others ignored
// - disable acts only with enable bit zero
// - disabled watchdog holds the binary counter at zero; dividers keep running
// - control is write-only, never read-modify-write
// - overflow interrupt is non-maskable
// - new overflow interrupt preempts earlier ones
// - internal reset lasts at most 24 fc
`timescale 1ns/1ps
module cwdt_top #(
  parameter int FC_EXP0 = cwdt_pkg::FC_TAP_EXP0,
  parameter int FS_EXP0 = cwdt_pkg::FS_TAP_EXP0
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic FS_PIN,
  input wire logic SLOW_MODE,
  input wire logic DIV_TAP_SEL,
  input wire logic STOP_MODE,
  input wire logic IDLE_MODE,
  input wire logic SLEEP_MODE,
  output logic WDT_RST_REQ,
  output logic WDT_NMI_REQ,
  output logic TRAP_ARM_STB
);

  logic watch_enable_bit_q;
  logic [1:0] detect_period_select_q;
  logic overflow_action_select_q;
  logic active_q;
  logic active_d;
  logic [FC_EXP0-1:0] fc_pre_q;
  logic [FS_EXP0-1:0] fs_pre_q;
  logic fs_s1_q;
  logic fs_s2_q;
  logic fs_s3_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic trap_q;
  logic nmi_q;
  logic rst_q;
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  cwdt_pkg::cwdt_out_t out_q;
  cwdt_pkg::cwdt_out_t out_d;

  // register port decode
  // command decodes one address above control
  wire wr_ctrl = REG_WR && (REG_ADDR == cwdt_pkg::ADDR_CTRL);
  wire wr_cmd = REG_WR && (REG_ADDR == cwdt_pkg::ADDR_CMD);
  wire rd_stat = REG_RD && (REG_ADDR == cwdt_pkg::ADDR_STAT);
  wire cmd_clr = wr_cmd && (REG_WDATA == cwdt_pkg::CMD_CLEAR);
  wire cmd_dis = wr_cmd && (REG_WDATA == cwdt_pkg::CMD_DISABLE);
  wire cmd_trap = wr_cmd && (REG_WDATA == cwdt_pkg::CMD_TRAP);

  wire wr_en = REG_WDATA[cwdt_pkg::CTL_EN_BIT];
  wire [1:0] wr_per = REG_WDATA[cwdt_pkg::CTL_PER_HI:cwdt_pkg::CTL_PER_LO];
  wire wr_act = REG_WDATA[cwdt_pkg::CTL_ACT_BIT];

  // stop, idle and sleep freeze counting
  wire pause = STOP_MODE || IDLE_MODE || SLEEP_MODE;

  // disable only once the enable bit is already zero
  always_comb begin
    active_d = active_q;
    if (wr_ctrl && wr_en) begin
      active_d = 1'b1;
    end else if (cmd_dis && !watch_enable_bit_q) begin
      active_d = 1'b0;
    end
  end

  // fc tap only in normal mode with tap select low
  wire use_fc = !SLOW_MODE && !DIV_TAP_SEL;
  wire [5:0] tap_step = {3'h0, detect_period_select_q, 1'b0};
  wire [5:0] fc_exp = 6'(FC_EXP0) - tap_step;
  wire [5:0] fs_exp = 6'(FS_EXP0) - tap_step;
  wire [FC_EXP0-1:0] fc_mask = (FC_EXP0'(1) << fc_exp) - FC_EXP0'(1);
  wire [FS_EXP0-1:0] fs_mask = (FS_EXP0'(1) << fs_exp) - FS_EXP0'(1);
  wire fs_edge = fs_s2_q && !fs_s3_q;
  wire fc_tick = !pause && ((fc_pre_q & fc_mask) == fc_mask);
  wire fs_tick = !pause && fs_edge && ((fs_pre_q & fs_mask) == fs_mask);
  wire tap_tick = use_fc ? fc_tick : fs_tick;

  // fs is asynchronous; only the second and third stages feed the edge detector
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
      fs_s3_q <= 1'b0;
    end else if (CE) begin
      fs_s1_q <= FS_PIN;
      fs_s2_q <= fs_s1_q;
      fs_s3_q <= fs_s2_q;
    end
  end

  // dividers never see the clear command
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      fc_pre_q <= '0;
      fs_pre_q <= '0;
    end else if (CE && !pause) begin
      fc_pre_q <= fc_pre_q + FC_EXP0'(1);
      if (fs_edge) begin
        fs_pre_q <= fs_pre_q + FS_EXP0'(1);
      end
    end
  end

  logic [1:0] bin_cnt;
  logic bin_ovf;

  // counter held at zero while disabled
  wire bin_clr = cmd_clr || !active_q;

  // clear reaches only the binary counter
  cwdt_bincnt #(
    .W(cwdt_pkg::BIN_W)
  ) u_bincnt (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .ce(CE),
    .clr(bin_clr),
    .hold(pause),
    .tick(tap_tick),
    .cnt(bin_cnt),
    .ovf(bin_ovf)
  );

  // enable bit and run state set during reset
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      watch_enable_bit_q <= cwdt_pkg::RST_EN_BIT;
      active_q <= cwdt_pkg::RST_EN_BIT;
      detect_period_select_q <= cwdt_pkg::RST_PER;
    end else if (CE) begin
      active_q <= active_d;
      if (wr_ctrl) begin
        watch_enable_bit_q <= wr_en;
        detect_period_select_q <= wr_per;
      end
    end
  end

  // action bit can only fall until the next reset
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      overflow_action_select_q <= cwdt_pkg::RST_ACT;
    end else if (CE && wr_ctrl) begin
      overflow_action_select_q <= overflow_action_select_q && wr_act;
    end
  end

  // control reads give no state; only status is readable
  wire [7:0] stat_word = {4'h0, active_q, bin_cnt, overflow_action_select_q};
  assign rdata_d = rd_stat ? stat_word : cwdt_pkg::RST_RDATA;

  // overflow sequencer picks reset or interrupt
  // every overflow with interrupt action, outside a reset request, gives a fresh interrupt pulse
  always_comb begin
    out_d = cwdt_pkg::OUT_IDLE;
    hold_d = 8'h00;
    case (out_q)
      cwdt_pkg::OUT_RST: begin
        if (hold_q != 8'h00) begin
          out_d = cwdt_pkg::OUT_RST;
          hold_d = hold_q - 8'h01;
        end
      end
      default: begin
        if (bin_ovf && overflow_action_select_q) begin
          out_d = cwdt_pkg::OUT_RST;
          // first request cycle plus hold_q counting down to one
          hold_d = 8'(cwdt_pkg::RST_HOLD_CYC - 1);
        end else if (bin_ovf) begin
          out_d = cwdt_pkg::OUT_NMI;
        end
      end
    endcase
  end

  // reset request stands a fixed count of fc periods
  // interrupt request goes out with no mask in its path
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      out_q <= cwdt_pkg::OUT_IDLE;
      hold_q <= 8'h00;
      rst_q <= 1'b0;
      nmi_q <= 1'b0;
      trap_q <= 1'b0;
      rdata_q <= cwdt_pkg::RST_RDATA;
    end else if (CE) begin
      out_q <= out_d;
      hold_q <= hold_d;
      rst_q <= (out_d == cwdt_pkg::OUT_RST);
      nmi_q <= (out_d == cwdt_pkg::OUT_NMI);
      trap_q <= cmd_trap;
      rdata_q <= rdata_d;
    end
  end

  assign WDT_RST_REQ = rst_q;
  assign WDT_NMI_REQ = nmi_q;
  assign TRAP_ARM_STB = trap_q;
  assign REG_RDATA = rdata_q;

  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  logic [7:0] rst_len_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rst_len_q <= 8'h00;
    end else if (CE) begin
      rst_len_q <= rst_q ? rst_len_q + 8'h01 : 8'h00;
    end
  end

  act_sticky_a: assert property (
    !overflow_action_select_q |=> !overflow_action_select_q)
    else $error("overflow action returned to reset");

  en_after_rst_a: assert property (
    $rose(RSTN) |-> watch_enable_bit_q && active_q)
    else $error("watchdog not enabled after reset");

  rst_on_ovf_a: assert property (
    CE && bin_ovf && overflow_action_select_q && (out_q != cwdt_pkg::OUT_RST)
    |=> WDT_RST_REQ && !WDT_NMI_REQ)
    else $error("overflow did not request reset");

  nmi_on_ovf_a: assert property (
    CE && bin_ovf && !overflow_action_select_q && (out_q != cwdt_pkg::OUT_RST)
    |=> WDT_NMI_REQ && !WDT_RST_REQ)
    else $error("overflow did not raise interrupt");

  pause_hold_a: assert property (
    CE && pause && active_q && !cmd_clr |=> $stable(bin_cnt) && $stable(fc_pre_q))
    else $error("count moved while paused");

  clear_div_a: assert property (
    CE && cmd_clr && !pause
    |=> bin_cnt == 2'h0 && fc_pre_q == $past(fc_pre_q) + FC_EXP0'(1))
    else $error("clear misbehaved");

  fc_tap_a: assert property (
    use_fc && tap_tick && detect_period_select_q == 2'h3
    |-> &fc_pre_q[FC_EXP0-7:0])
    else $error("fc tap fired early");

  dis_gate_a: assert property (
    CE && cmd_dis && watch_enable_bit_q && active_q |=> active_q)
    else $error("disable took effect with enable set");

  dis_zero_a: assert property (
    !active_q ##1 !active_q |-> bin_cnt == 2'h0)
    else $error("counter moved while disabled");

  ctl_read_a: assert property (
    REG_RD && REG_ADDR == cwdt_pkg::ADDR_CTRL && CE |=> REG_RDATA == 8'h00)
    else $error("control read leaked state");

  nmi_pulse_a: assert property (
    WDT_NMI_REQ && CE |=> !WDT_NMI_REQ)
    else $error("interrupt request not a single pulse");

  rst_len_a: assert property (
    rst_len_q <= 8'(cwdt_pkg::RST_TIME_FC))
    else $error("reset request too long");

  ovf_rst_c: cover property (WDT_RST_REQ ##1 !WDT_RST_REQ);
  ovf_nmi_c: cover property (WDT_NMI_REQ);
  disable_c: cover property (active_q ##1 !active_q);
  clr_c: cover property (cmd_clr && bin_cnt != 2'h0);

endmodule

// ### tb_cpu_watchdog_timer.sv
/*
  self-checking bench for cwdt_top: register writes and status reads,
  overflow actions, clear, disable, pause modes and period select.
  assumes shortened taps FC_EXP0=8, FS_EXP0=7 and a free fs pin.
*/
`timescale 1ns/1ps
module tb_cpu_watchdog_timer;
  localparam int FC_E = 8;
  localparam int FS_E = 7;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic fs_pin = 1'b0;
  logic slow_mode = 1'b0;
  logic div_tap_sel = 1'b0;
  logic [2:0] pause = 3'h0;
  logic rst_req;
  logic nmi_req;
  logic trap_stb;
  logic ev_seen = 1'b0;
  logic [7:0] rd;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int trap_n = 0;
  int n;

  cwdt_top #(.FC_EXP0(FC_E), .FS_EXP0(FS_E)) u_cwdt_top (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(1'b1), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .FS_PIN(fs_pin), .SLOW_MODE(slow_mode), .DIV_TAP_SEL(div_tap_sel),
    .STOP_MODE(pause[0]), .IDLE_MODE(pause[1]), .SLEEP_MODE(pause[2]),
    .WDT_RST_REQ(rst_req), .WDT_NMI_REQ(nmi_req), .TRAP_ARM_STB(trap_stb)
  );

  always #12.5 clk_sys = ~clk_sys;

  // fs runs free at one eighth of the system clock; slow enough for the synchroniser
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) fs_pin <= ~fs_pin;
    if (rst_req === 1'b1 || nmi_req === 1'b1) ev_seen <= 1'b1;
    if (trap_stb === 1'b1) trap_n <= trap_n + 1;
    if (cyc == 40000) begin
      $display("BAD t=%0t run did not finish", $time);
      err_total++;
      results();
    end
  end

  task results;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task idle_n(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // counts edges until the chosen request is seen high, capped at lim
  task wait_req(input logic nmi, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1 cnt++;
    end while (((nmi ? nmi_req : rst_req) !== 1'b1) && cnt < lim);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(2'h2, rd);
    chk(rd, 8'h09, "status after reset");
    rd_reg(2'h0, rd);
    chk(rd, 8'h00, "control read");
    rd_reg(2'h1, rd);
    chk(rd, 8'h00, "command read");
    wr(2'h3, 8'h4e);
    rd_reg(2'h3, rd);
    chk(rd, 8'h00, "unmapped read");
    wr(2'h1, 8'hd2);
    idle_n(3);
    chk(trap_n, 1, "trap strobe");
    wr(2'h0, 8'h0f);
    wr(2'h1, 8'h4e);
    wr(2'h1, 8'h00);
    wr(2'h1, 8'hff);
    wr(2'h1, 8'h4f);
    wait_req(1'b0, 20, n);
    chk(n < 20, 1, "reset request after overflow");
    n = 0;
    while (rst_req === 1'b1 && n < 40) begin
      n++;
      idle_n(1);
    end
    chk(n, 24, "reset request length");
    // clears every 8 cycles stay well inside three quarters of 16
    wr(2'h1, 8'h4e);
    ev_seen = 1'b0;
    repeat (12) begin
      idle_n(6);
      wr(2'h1, 8'h4e);
    end
    chk(ev_seen, 1'b0, "no overflow while cleared");
    wr(2'h1, 8'hb1);
    rd_reg(2'h2, rd);
    chk(rd[3], 1'b1, "disable refused while enabled");
    wr(2'h1, 8'h4e);
    wr(2'h0, 8'h07);
    wr(2'h1, 8'hb1);
    idle_n(30);
    ev_seen = 1'b0;
    rd_reg(2'h2, rd);
    chk(rd, 8'h01, "disabled, counter zero");
    idle_n(100);
    chk(ev_seen, 1'b0, "no overflow when disabled");
    wr(2'h0, 8'h0f);
    for (int m = 0; m < 3; m++) begin
      pause <= 3'h1 << m;
      wr(2'h1, 8'h4e);
      idle_n(30);
      ev_seen = 1'b0;
      idle_n(100);
      chk(ev_seen, 1'b0, "frozen while paused");
      pause <= 3'h0;
      wait_req(1'b0, 20, n);
      chk(n < 20, 1, "count resumes after pause");
      idle_n(30);
    end
    wr(2'h0, 8'h0e);
    wr(2'h0, 8'h0f);
    rd_reg(2'h2, rd);
    chk(rd & 8'h09, 8'h08, "interrupt action sticks");
    // overflows during a reset request are dropped; let it finish first
    while (rst_req === 1'b1) idle_n(1);
    wr(2'h1, 8'h4e);
    wait_req(1'b1, 20, n);
    chk(n < 20, 1, "interrupt on overflow");
    chk(rst_req, 1'b0, "no reset with interrupt action");
    idle_n(1);
    chk(nmi_req, 1'b0, "interrupt pulse one cycle");
    for (int c = 3; c >= 0; c--) begin
      wr(2'h0, 8'h08 | 8'(c << 1));
      wr(2'h1, 8'h4e);
      wait_req(1'b1, 3000, n);
      wait_req(1'b1, 3000, n);
      chk(n, 1 << (FC_E + 2 - 2 * c), "fc period");
    end
    div_tap_sel <= 1'b1;
    for (int c = 3; c >= 2; c--) begin
      wr(2'h0, 8'h08 | 8'(c << 1));
      wait_req(1'b1, 3000, n);
      wait_req(1'b1, 3000, n);
      chk(n, 8 << (FS_E + 2 - 2 * c), "fs period by tap");
    end
    div_tap_sel <= 1'b0;
    slow_mode <= 1'b1;
    wr(2'h0, 8'h0e);
    wait_req(1'b1, 3000, n);
    wait_req(1'b1, 3000, n);
    chk(n, 8 << (FS_E - 4), "fs period in slow mode");
    chk(trap_n, 1, "no stray trap strobe");
    results();
  end
endmodule
